// >>> hw/fbm_consts.svh
`ifndef FBM_CONSTS_SVH
`define FBM_CONSTS_SVH

// Core clock rate in MHz
`define FBM_CLK_MHZ 32'd25

// Feedback levels, millivolt codes
`define FBM_V_BURST 16'h0320
`define FBM_V_ON 16'h04b0
`define FBM_V_SW 16'h07d0
`define FBM_CEIL_START 16'h04b0
`define FBM_V_REF 16'h097c

// Timing: printed figures and derived cycle counts
`define FBM_FMIN_HZ 32'd20000
`define FBM_MAXPER_CYC 16'((`FBM_CLK_MHZ * 32'd1000000) / `FBM_FMIN_HZ)
`define FBM_LEB_NS 32'd480
`define FBM_LEB_CYC 16'((`FBM_LEB_NS * `FBM_CLK_MHZ + 32'd999) / 32'd1000)
`define FBM_HALF_SINE_US 32'd9823
`define FBM_CNT_SAT 16'hffff
`define FBM_PULSE_SAT 8'hff
`define FBM_BURST_SHIFT 4

// Register byte addresses
`define FBM_REG_CTRL 8'h00
`define FBM_REG_STATUS 8'h04
`define FBM_REG_TON 8'h08
`define FBM_REG_PERIOD 8'h0c
`define FBM_REG_BURST 8'h10
`define FBM_REG_BURSTN 8'h14
`define FBM_REG_FBLVL 8'h18
`define FBM_REG_DEMAG 8'h1c
`define FBM_REG_VOUT 8'h20
`define FBM_REG_VIN 8'h24
`define FBM_REG_VINOV 8'h28
`define FBM_REG_OCP 8'h2c
`define FBM_REG_LIMITS 8'h30
`define FBM_REG_OCPNOW 8'h34

// Control register bits
`define FBM_CTRL_RUN 0
`define FBM_CTRL_BIN 1

`endif

// >>> hw/fbm_pkg.sv
package fbm_pkg;

	typedef enum logic [1:0] {MODE_IDLE, MODE_FIRST_VALLEY, MODE_DISCONT, MODE_BURST} fbm_mode_t;
	typedef enum logic {PH_OFF, PH_ON} fbm_phase_t;

	// Registered values from the sensing front end
	typedef struct packed {
		logic [15:0] valley_period;
		logic [15:0] vin;
		logic [15:0] vin_peak;
		logic [15:0] fb;
		logic fb_valid;
	} fbm_sense_t;

	typedef struct packed {
		logic run;
		logic burst_in_en;
		logic [15:0] ton_min;
		logic [15:0] ton_max_low;
		logic [15:0] maxf_period;
		logic [15:0] blank;
		logic [15:0] burst_period;
		logic [15:0] burst_min_on;
		logic [7:0] min_pulses;
		logic [15:0] step;
		logic [15:0] floor_lvl;
		logic [15:0] max_map;
		logic [15:0] demag;
		logic [15:0] ratio;
		logic [15:0] vout_ov;
		logic [15:0] foldback;
		logic [15:0] vin_low;
		logic [15:0] vin_high;
		logic [15:0] vin_ov;
		logic [15:0] ocp_low;
		logic [15:0] ocp_high;
	} fbm_cfg_t;

	typedef struct packed {
		fbm_cfg_t cfg;
		fbm_mode_t mode;
		fbm_phase_t phase;
		logic ack;
		logic slverr;
		logic [31:0] prdata;
		logic valley_s1;
		logic valley_s2;
		logic valley_d;
		logic cs_s1;
		logic cs_s2;
		logic valley_seen;
		logic gate;
		logic [15:0] fb;
		logic [15:0] fb_cap;
		logic [15:0] sw_cnt;
		logic [15:0] on_cnt;
		logic [15:0] ton_cur;
		logic [15:0] ton_min_eff;
		logic [15:0] ton_max;
		logic [15:0] ocp;
		logic [15:0] ceiling;
		logic [31:0] half_cnt;
		logic [15:0] blank_cnt;
		logic [15:0] burst_cnt;
		logic [7:0] pulse_left;
		logic [15:0] burst_ton;
	} fbm_state_t;

	// Clamped linear interpolation, falling or rising
	function automatic logic [15:0] fbm_lerp(input logic [15:0] y0, input logic [15:0] y1,
		input logic [15:0] x, input logic [15:0] x0, input logic [15:0] x1);
		logic [15:0] r;
		r = y0;
		if (x <= x0) begin
			r = y0;
		end else if (x >= x1) begin
			r = y1;
		end else if (y1 >= y0) begin
			r = y0 + 16'((32'(y1 - y0) * 32'(x - x0)) / 32'(x1 - x0));
		end else begin
			r = y0 - 16'((32'(y0 - y1) * 32'(x - x0)) / 32'(x1 - x0));
		end
		return r;
	endfunction : fbm_lerp

endpackage : fbm_pkg

// >>> hw/fbm_top.sv
`include "fbm_consts.svh"

// Behaviour
// - Feedback at least 1.2 V and mapped period below valley period: first-valley mode.
// - First-valley mode turns the switch on at the first valley.
// - Feedback between 0.8 V and 1.2 V: discontinuous mode with adapted minimum on-time.
// - Feedback at least 1.2 V but period above valley period: discontinuous mode.
// - Discontinuous mode turns the switch on later than the first valley.
// - Below 0.8 V for blanking time enters burst; above 0.8 V leaves it.
// - Burst uses the 50 us maximum period and a configured burst repetition.
// - Burst pulse count and on-time come from live feedback at entry, then from feedback captured at last pulse.
// - At or below feedback floor: burst minimum on-time and minimum pulse count.
// - Burst disables output protections; input protections only if enabled.
// - Sensing minimum on-time is demag time times ratio times overvoltage over peak.
// - Effective minimum on-time is the larger of configured and sensing minimum.
// - Between low and overvoltage input, maximum on-time scales by low over input.
// - Below low input, maximum on-time folds back by gain times relative shortfall.
// - On-time limits update once per half-sine period, line-synced or 9.823 ms.
// - Minimum period falls from 50 us at 0.8 V to configured period at 2.0 V.
// - Current limit interpolates between endpoints over input range, clamped outside.
// - At maximum map level pulses end at maximum on-time or current limit.
// - Current limit updates per half-sine and is ignored during 480 ns blanking.
// - On regulated entry ceiling ramps from 1.2 V to 2.428 V, one step per half-sine.
// - Feedback above the ceiling is mapped from the ceiling, else from itself.
// - Filtered feedback samples are taken from the front end before mapping.
module fbm_top import fbm_pkg::*; #(
	parameter int unsigned HALF_SINE_CYC = `FBM_HALF_SINE_US * `FBM_CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire fbm_sense_t sense_i,
	input wire logic line_sync_i,
	input wire logic half_tick_i,
	input wire logic valley_pin_i,
	input wire logic cs_trip_pin_i,
	output logic gate_o,
	output logic [15:0] current_sense_limit_o,
	output logic out_prot_en_o,
	output logic in_prot_en_o,
	output fbm_mode_t mode_o
);

	if (HALF_SINE_CYC < 32'd2) begin : g_chk
		$error("HALF_SINE_CYC must be at least 2");
	end

	fbm_state_t s;
	fbm_state_t next_s;

	logic [15:0] mfb;
	logic [15:0] minper;
	logic [15:0] ton_map;
	logic fv_ok;
	fbm_mode_t map_mode;
	logic half_tick;
	logic valley_edge;
	logic entry;
	logic [47:0] prod48;
	logic [47:0] red48;
	logic [31:0] t32;
	logic [15:0] vin_c;
	logic [15:0] tmax;
	logic [15:0] tsense;
	logic [16:0] ceil_sum;
	logic [15:0] bsrc;
	logic [15:0] bn16;
	logic [31:0] rd;
	logic hit;
	logic start;

	always_comb begin
		next_s = s;
		// Pin synchronisers; only the second stage and the valley edge delay feed logic
		next_s.valley_s1 = valley_pin_i;
		next_s.valley_s2 = s.valley_s1;
		next_s.valley_d = s.valley_s2;
		next_s.cs_s1 = cs_trip_pin_i;
		next_s.cs_s2 = s.cs_s1;
		valley_edge = s.valley_s2 && !s.valley_d;
		if (sense_i.fb_valid) begin
			next_s.fb = sense_i.fb;
		end

		// Mapping value clipped by the startup ceiling
		mfb = (s.fb > s.ceiling) ? s.ceiling : s.fb;
		minper = fbm_lerp(`FBM_MAXPER_CYC, s.cfg.maxf_period, mfb, `FBM_V_BURST, `FBM_V_SW);
		fv_ok = minper < sense_i.valley_period;
		map_mode = (mfb >= `FBM_V_ON && fv_ok) ? MODE_FIRST_VALLEY : MODE_DISCONT;
		ton_map = fbm_lerp(s.ton_min_eff, s.ton_max, mfb, `FBM_V_ON, s.cfg.max_map);
		if (ton_map < s.ton_min_eff) begin
			ton_map = s.ton_min_eff;
		end

		// Half-sine time base: line tick when synced, else internal period
		if (line_sync_i) begin
			half_tick = half_tick_i;
			next_s.half_cnt = 32'h0;
		end else begin
			half_tick = (s.half_cnt >= HALF_SINE_CYC - 32'd1);
			next_s.half_cnt = half_tick ? 32'h0 : s.half_cnt + 32'd1;
		end

		// Sensing minimum on-time; a zero peak reading saturates it
		prod48 = (48'(s.cfg.demag) * 48'(s.cfg.ratio) * 48'(s.cfg.vout_ov)) >> 8;
		if (sense_i.vin_peak == 16'h0) begin
			tsense = `FBM_CNT_SAT;
		end else begin
			prod48 = prod48 / 48'(sense_i.vin_peak);
			tsense = (prod48 > 48'(`FBM_CNT_SAT)) ? `FBM_CNT_SAT : 16'(prod48);
		end

		// Maximum on-time versus input, flat above the overvoltage level
		vin_c = (sense_i.vin > s.cfg.vin_ov) ? s.cfg.vin_ov : sense_i.vin;
		t32 = 32'h0;
		red48 = 48'h0;
		if (vin_c >= s.cfg.vin_low) begin
			if (vin_c == 16'h0) begin
				tmax = s.cfg.ton_max_low;
			end else begin
				t32 = (32'(s.cfg.ton_max_low) * 32'(s.cfg.vin_low)) / 32'(vin_c);
				tmax = 16'(t32);
			end
		end else begin
			red48 = (48'(s.cfg.ton_max_low) * 48'(s.cfg.foldback) * 48'(s.cfg.vin_low - vin_c))
				/ (48'(s.cfg.vin_low) << 8);
			tmax = (red48 >= 48'(s.cfg.ton_max_low)) ? 16'h0 : s.cfg.ton_max_low - 16'(red48);
		end

		// Burst pulse count and width from live feedback at entry, then from the captured feedback
		bsrc = (s.mode == MODE_BURST) ? s.fb_cap : s.fb;
		bn16 = 16'(s.cfg.min_pulses);
		if (bsrc > s.cfg.floor_lvl) begin
			bn16 = bn16 + ((bsrc - s.cfg.floor_lvl) >> `FBM_BURST_SHIFT);
		end

		entry = s.cfg.run && (s.mode == MODE_IDLE);
		ceil_sum = 17'(s.ceiling) + 17'(s.cfg.step);

		// Limits refresh on each half-sine and at regulated entry
		if (half_tick || entry) begin
			next_s.ton_min_eff = (tsense > s.cfg.ton_min) ? tsense : s.cfg.ton_min;
			next_s.ton_max = tmax;
			next_s.ocp = fbm_lerp(s.cfg.ocp_low, s.cfg.ocp_high, sense_i.vin, s.cfg.vin_low,
				s.cfg.vin_high);
		end
		if (entry) begin
			next_s.ceiling = `FBM_CEIL_START;
		end else if (half_tick && s.cfg.run) begin
			next_s.ceiling = (ceil_sum > 17'(`FBM_V_REF)) ? `FBM_V_REF : 16'(ceil_sum);
		end

		// Mode selection
		start = 1'b0;
		case (s.mode)
			MODE_IDLE: begin
				next_s.blank_cnt = 16'h0;
				if (s.cfg.run) begin
					next_s.mode = map_mode;
				end
			end
			MODE_FIRST_VALLEY, MODE_DISCONT: begin
				next_s.mode = map_mode;
				if (s.fb < `FBM_V_BURST) begin
					next_s.blank_cnt = (s.blank_cnt == `FBM_CNT_SAT) ? s.blank_cnt : s.blank_cnt + 16'h1;
					if (s.blank_cnt >= s.cfg.blank) begin
						next_s.mode = MODE_BURST;
						next_s.blank_cnt = 16'h0;
						next_s.burst_cnt = 16'h0;
						next_s.pulse_left = (bn16 > 16'(`FBM_PULSE_SAT)) ? `FBM_PULSE_SAT : 8'(bn16);
						next_s.burst_ton = (bsrc > s.cfg.floor_lvl) ?
							s.cfg.burst_min_on + (bsrc - s.cfg.floor_lvl) : s.cfg.burst_min_on;
					end
				end else begin
					next_s.blank_cnt = 16'h0;
				end
			end
			MODE_BURST: begin
				if (s.fb > `FBM_V_BURST) begin
					next_s.mode = map_mode;
				end else if (17'(s.burst_cnt) + 17'h1 >= 17'(s.cfg.burst_period)) begin
					next_s.burst_cnt = 16'h0;
					next_s.pulse_left = (bn16 > 16'(`FBM_PULSE_SAT)) ? `FBM_PULSE_SAT : 8'(bn16);
					next_s.burst_ton = (bsrc > s.cfg.floor_lvl) ?
						s.cfg.burst_min_on + (bsrc - s.cfg.floor_lvl) : s.cfg.burst_min_on;
				end else begin
					next_s.burst_cnt = s.burst_cnt + 16'h1;
				end
			end
			default: begin
				next_s.mode = MODE_IDLE;
			end
		endcase

		// Switching cycle; a saturated off count restarts a stalled converter
		case (s.phase)
			PH_OFF: begin
				next_s.sw_cnt = (s.sw_cnt == `FBM_CNT_SAT) ? s.sw_cnt : s.sw_cnt + 16'h1;
				if (valley_edge) begin
					next_s.valley_seen = 1'b1;
				end
				case (s.mode)
					MODE_FIRST_VALLEY: start = (s.sw_cnt >= minper && valley_edge) ||
						s.sw_cnt == `FBM_CNT_SAT;
					MODE_DISCONT: start = (s.sw_cnt >= minper && valley_edge && s.valley_seen) ||
						s.sw_cnt == `FBM_CNT_SAT;
					MODE_BURST: start = s.sw_cnt >= `FBM_MAXPER_CYC && s.pulse_left != 8'h0;
					default: start = 1'b0;
				endcase
				if (start && s.cfg.run) begin
					next_s.phase = PH_ON;
					next_s.gate = 1'b1;
					next_s.sw_cnt = 16'h0;
					next_s.on_cnt = 16'h0;
					next_s.valley_seen = 1'b0;
					next_s.ton_cur = (s.mode == MODE_BURST) ? s.burst_ton : ton_map;
				end
			end
			PH_ON: begin
				next_s.sw_cnt = s.sw_cnt + 16'h1;
				next_s.on_cnt = s.on_cnt + 16'h1;
				// Current trip is blind during the leading-edge spike
				if (17'(s.on_cnt) + 17'h1 >= 17'(s.ton_cur) ||
					(s.cs_s2 && s.on_cnt >= `FBM_LEB_CYC) || !s.cfg.run) begin
					next_s.phase = PH_OFF;
					next_s.gate = 1'b0;
					if (s.mode == MODE_BURST && s.pulse_left != 8'h0) begin
						next_s.pulse_left = s.pulse_left - 8'h1;
						if (s.pulse_left == 8'h1) begin
							next_s.fb_cap = s.fb;
						end
					end
				end
			end
			default: begin
				next_s.phase = PH_OFF;
				next_s.gate = 1'b0;
			end
		endcase
		if (!s.cfg.run) begin
			next_s.mode = MODE_IDLE;
		end

		// APB read mux
		hit = 1'b1;
		case (paddr_i)
			`FBM_REG_CTRL: rd = {30'h0, s.cfg.burst_in_en, s.cfg.run};
			`FBM_REG_STATUS: rd = {s.ceiling, 13'h0, s.gate, 2'(s.mode)};
			`FBM_REG_TON: rd = {s.cfg.ton_max_low, s.cfg.ton_min};
			`FBM_REG_PERIOD: rd = {s.cfg.blank, s.cfg.maxf_period};
			`FBM_REG_BURST: rd = {s.cfg.burst_min_on, s.cfg.burst_period};
			`FBM_REG_BURSTN: rd = {s.cfg.step, 8'h0, s.cfg.min_pulses};
			`FBM_REG_FBLVL: rd = {s.cfg.max_map, s.cfg.floor_lvl};
			`FBM_REG_DEMAG: rd = {s.cfg.ratio, s.cfg.demag};
			`FBM_REG_VOUT: rd = {s.cfg.foldback, s.cfg.vout_ov};
			`FBM_REG_VIN: rd = {s.cfg.vin_high, s.cfg.vin_low};
			`FBM_REG_VINOV: rd = {16'h0, s.cfg.vin_ov};
			`FBM_REG_OCP: rd = {s.cfg.ocp_high, s.cfg.ocp_low};
			`FBM_REG_LIMITS: rd = {s.ton_max, s.ton_min_eff};
			`FBM_REG_OCPNOW: rd = {16'h0, s.ocp};
			default: begin
				rd = 32'h0;
				hit = 1'b0;
			end
		endcase

		// One wait state: answer latched, write lands on the ready edge
		next_s.ack = 1'b0;
		if (psel_i && penable_i && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.prdata = pwrite_i ? 32'h0 : rd;
			next_s.slverr = !hit;
		end
		if (psel_i && penable_i && s.ack && pwrite_i) begin
			case (paddr_i)
				`FBM_REG_CTRL: begin
					next_s.cfg.run = pwdata_i[`FBM_CTRL_RUN];
					next_s.cfg.burst_in_en = pwdata_i[`FBM_CTRL_BIN];
				end
				`FBM_REG_TON: {next_s.cfg.ton_max_low, next_s.cfg.ton_min} = pwdata_i;
				`FBM_REG_PERIOD: {next_s.cfg.blank, next_s.cfg.maxf_period} = pwdata_i;
				`FBM_REG_BURST: {next_s.cfg.burst_min_on, next_s.cfg.burst_period} = pwdata_i;
				`FBM_REG_BURSTN: begin
					next_s.cfg.step = pwdata_i[31:16];
					next_s.cfg.min_pulses = pwdata_i[7:0];
				end
				`FBM_REG_FBLVL: {next_s.cfg.max_map, next_s.cfg.floor_lvl} = pwdata_i;
				`FBM_REG_DEMAG: {next_s.cfg.ratio, next_s.cfg.demag} = pwdata_i;
				`FBM_REG_VOUT: {next_s.cfg.foldback, next_s.cfg.vout_ov} = pwdata_i;
				`FBM_REG_VIN: {next_s.cfg.vin_high, next_s.cfg.vin_low} = pwdata_i;
				`FBM_REG_VINOV: next_s.cfg.vin_ov = pwdata_i[15:0];
				`FBM_REG_OCP: {next_s.cfg.ocp_high, next_s.cfg.ocp_low} = pwdata_i;
				default: begin
				end
			endcase
		end
	end

	// Whole state in one register; reset gives a stopped, unconfigured block
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata_o = s.prdata;
	assign pready_o = s.ack;
	assign pslverr_o = s.ack && s.slverr;
	assign gate_o = s.gate;
	assign current_sense_limit_o = s.ocp;
	assign mode_o = s.mode;
	assign out_prot_en_o = s.cfg.run && s.mode != MODE_BURST;
	assign in_prot_en_o = s.cfg.run && (s.mode != MODE_BURST || s.cfg.burst_in_en);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence seq_run_rise;
		!s.cfg.run ##1 s.cfg.run;
	endsequence
	sequence seq_pulse_start;
		s.phase == PH_OFF ##1 $rose(s.gate);
	endsequence

	property p_ceiling_start;
		seq_run_rise |=> s.ceiling == `FBM_CEIL_START && s.mode != MODE_IDLE;
	endproperty
	a_ceiling_start: assert property (p_ceiling_start) else $error("ceiling not reset on entry");
	property p_ceiling_bound;
		s.cfg.run && s.mode != MODE_IDLE |=> s.ceiling <= `FBM_V_REF && s.ceiling >= $past(s.ceiling);
	endproperty
	a_ceiling_bound: assert property (p_ceiling_bound) else $error("ceiling out of ramp");
	property p_fv_select;
		s.cfg.run && s.mode inside {MODE_FIRST_VALLEY, MODE_DISCONT} && mfb >= `FBM_V_ON && fv_ok
			|=> s.mode == MODE_FIRST_VALLEY;
	endproperty
	a_fv_select: assert property (p_fv_select) else $error("first valley mode not chosen");
	property p_discont_low;
		s.cfg.run && s.mode inside {MODE_FIRST_VALLEY, MODE_DISCONT} && s.fb >= `FBM_V_BURST && mfb < `FBM_V_ON
			|=> s.mode == MODE_DISCONT;
	endproperty
	a_discont_low: assert property (p_discont_low) else $error("discontinuous mode not chosen");
	property p_discont_high;
		s.cfg.run && s.mode != MODE_IDLE && mfb >= `FBM_V_ON && !fv_ok |=> s.mode == MODE_DISCONT;
	endproperty
	a_discont_high: assert property (p_discont_high) else $error("slow period not discontinuous");
	property p_burst_entry;
		s.cfg.run && s.mode inside {MODE_FIRST_VALLEY, MODE_DISCONT} && s.fb < `FBM_V_BURST &&
			s.blank_cnt >= s.cfg.blank |=> s.mode == MODE_BURST;
	endproperty
	a_burst_entry: assert property (p_burst_entry) else $error("burst not entered");
	property p_burst_exit;
		s.cfg.run && s.mode == MODE_BURST && s.fb > `FBM_V_BURST |=> s.mode != MODE_BURST;
	endproperty
	a_burst_exit: assert property (p_burst_exit) else $error("burst not left");
	property p_prot;
		s.mode == MODE_BURST && s.cfg.run |-> !out_prot_en_o && (in_prot_en_o == s.cfg.burst_in_en);
	endproperty
	a_prot: assert property (p_prot) else $error("protection enables wrong in burst");
	property p_leb;
		$fell(s.gate) && $past(s.cfg.run) && 17'($past(s.on_cnt)) + 17'h1 < 17'($past(s.ton_cur))
			|-> $past(s.on_cnt) >= `FBM_LEB_CYC;
	endproperty
	a_leb: assert property (p_leb) else $error("pulse cut inside blanking");
	property p_burst_period;
		s.mode == MODE_BURST ##0 seq_pulse_start |-> $past(s.sw_cnt) >= `FBM_MAXPER_CYC;
	endproperty
	a_burst_period: assert property (p_burst_period) else $error("burst pulse too early");
	property p_min_on;
		$rose(s.gate) && $past(s.mode) inside {MODE_FIRST_VALLEY, MODE_DISCONT} |-> s.ton_cur >= $past(s.ton_min_eff);
	endproperty
	a_min_on: assert property (p_min_on) else $error("on-time below minimum");
	property p_min_period;
		$rose(s.gate) && $past(s.mode) inside {MODE_FIRST_VALLEY, MODE_DISCONT} &&
			$past(s.sw_cnt) != `FBM_CNT_SAT |-> $past(s.sw_cnt) >= $past(minper);
	endproperty
	a_min_period: assert property (p_min_period) else $error("period below mapped minimum");
	property p_valley_on;
		$rose(s.gate) && $past(s.mode) == MODE_FIRST_VALLEY && $past(s.sw_cnt) != `FBM_CNT_SAT |-> $past(valley_edge);
	endproperty
	a_valley_on: assert property (p_valley_on) else $error("turn-on off the valley");

endmodule : fbm_top

// >>> test/fbm_stage_model.sv
// Power stage seen from the gate: switch current and winding ringing
module fbm_stage_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic gate_i,
	input wire logic [15:0] trip_after_i,
	input wire logic [15:0] ring_i,
	output logic valley_pin_o,
	output logic cs_trip_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] on_cnt;
	logic [15:0] off_cnt;

	// On and off time counters, each cleared by the other phase
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			on_cnt <= 16'h0000;
			off_cnt <= 16'h0000;
		end else if (gate_i) begin
			on_cnt <= on_cnt + 16'h0001;
			off_cnt <= 16'h0000;
		end else begin
			on_cnt <= 16'h0000;
			off_cnt <= off_cnt + 16'h0001;
		end
	end

	// Current crosses the limit after a set on time; a large setting means never
	assign cs_trip_pin_o = gate_i && (on_cnt >= trip_after_i);
	// Valley window of 4 cycles at the end of every ring period while off
	assign valley_pin_o = !gate_i && ((off_cnt % ring_i) >= (ring_i - 16'h0004));
endmodule : fbm_stage_model

// >>> test/fbm_top_tb.sv
`include "fbm_consts.svh"

module fbm_top_tb import fbm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, gate, oen, ien, vpin, cspin, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, q;
	logic [15:0] csl, trip = 16'hffff;
	logic lsync = 1'b0, htick = 1'b0;
	fbm_mode_t mode;
	fbm_sense_t sense = '0;
	int n_mismatch = 0, n_compared = 0, cyc = 0, npulse = 0, wcnt = 0, gcnt = 0, last_w = 0, last_g = 0, v, k;
	integer seed = 32'hec90f992;
	logic [7:0] ra [10] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
	logic [31:0] rd [10] = '{32'h03e8012c, 32'h001400fa, 32'h00321388, 32'h00640002, 32'h07d00258,
		32'h02000064, 32'h010003e8, 32'h012c0064, 32'h00000190, 32'h00c80258};
	int vt [4] = '{50, 100, 300, 350};

	always #20 clk_i = ~clk_i;

	// Short half-sine period keeps the limit updates and ramp quick
	fbm_top #(.HALF_SINE_CYC(64)) i_fbm_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .sense_i(sense), .line_sync_i(lsync), .half_tick_i(htick), .valley_pin_i(vpin),
		.cs_trip_pin_i(cspin), .gate_o(gate), .current_sense_limit_o(csl), .out_prot_en_o(oen),
		.in_prot_en_o(ien), .mode_o(mode));
	fbm_stage_model i_fbm_stage_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .gate_i(gate), .trip_after_i(trip),
		.ring_i(16'h07d0), .valley_pin_o(vpin), .cs_trip_pin_o(cspin));

	// Gate pulse width and preceding gap, plus the hang limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (gate === 1'b1) begin
			wcnt <= wcnt + 1;
			if (wcnt == 0) begin
				last_g <= gcnt;
			end
			gcnt <= 0;
		end else begin
			gcnt <= gcnt + 1;
			if (wcnt != 0) begin
				last_w <= wcnt;
				npulse <= npulse + 1;
			end
			wcnt <= 0;
		end
		if (cyc == 60000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	// Tolerance of one code for integer rounding
	task automatic near(input logic [15:0] x, input int ex, input string m);
		chk(((17'(x) + 17'd1) >= 17'(ex)) && (17'(x) <= 17'(ex + 1)), m);
	endtask : near

	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic pulses(input int n);
		k = npulse;
		wait (npulse >= k + n);
	endtask : pulses

	function automatic int exp_ocp(input int x);
		if (x <= 100) return 600;
		if (x >= 300) return 200;
		return 600 - (400 * (x - 100)) / 200;
	endfunction : exp_ocp

	function automatic int exp_tmax(input int x);
		if (x >= 100) return 100000 / x;
		return 1000 - (1000 * (100 - x)) / 100;
	endfunction : exp_tmax

	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		chk(mode === MODE_IDLE && gate === 1'b0 && oen === 1'b0, "reset outputs");
		rst_b_i <= 1'b1;
		sense <= '{16'h07d0, 16'h00c8, 16'h0190, 16'h05dc, 1'b1};
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, ra[i], rd[i]);
			apb(1'b0, ra[i], 32'h00000000);
			chk(q === rd[i] && e === 1'b0, "readback");
		end
		apb(1'b0, 8'h38, 32'h00000000);
		chk(e === 1'b1 && q === 32'h00000000, "unmapped");
		$display("test done: registers");
		apb(1'b1, `FBM_REG_CTRL, 32'h00000001);
		repeat (3) @(posedge clk_i);
		chk(mode === MODE_FIRST_VALLEY && oen === 1'b1, "valley mode");
		apb(1'b0, `FBM_REG_STATUS, 32'h00000000);
		chk(q[31:16] === `FBM_CEIL_START, "ceiling start");
		apb(1'b1, `FBM_REG_LIMITS, 32'hffffffff);
		repeat (140) @(posedge clk_i);
		apb(1'b0, `FBM_REG_LIMITS, 32'h00000000);
		chk(q === 32'h01f401f4, "on limits");
		for (int i = 0; i < 8; i++) begin
			v = (i < 4) ? vt[i] : 100 + {$random(seed)} % 201;
			sense.vin <= 16'(v);
			repeat (140) @(posedge clk_i);
			apb(1'b0, `FBM_REG_OCPNOW, 32'h00000000);
			near(q[15:0], exp_ocp(v), "current limit");
			chk(csl === q[15:0], "limit pin");
			apb(1'b0, `FBM_REG_LIMITS, 32'h00000000);
			near(q[31:16], exp_tmax(v), "max on");
		end
		// Line-synced time base: limits must wait for the external half-sine tick
		lsync <= 1'b1;
		sense.vin <= 16'h00fa;
		repeat (140) @(posedge clk_i);
		apb(1'b0, `FBM_REG_LIMITS, 32'h00000000);
		near(q[31:16], exp_tmax(v), "held without tick");
		htick <= 1'b1;
		@(posedge clk_i);
		htick <= 1'b0;
		apb(1'b0, `FBM_REG_LIMITS, 32'h00000000);
		near(q[31:16], exp_tmax(250), "line tick update");
		lsync <= 1'b0;
		sense.vin <= 16'h00c8;
		apb(1'b0, `FBM_REG_STATUS, 32'h00000000);
		chk(q[31:16] === `FBM_V_REF, "ceiling top");
		$display("test done: limits");
		sense.valley_period <= 16'h012c;
		repeat (3) @(posedge clk_i);
		chk(mode === MODE_DISCONT, "period above valley");
		sense <= '{16'h07d0, 16'h00c8, 16'h0190, 16'h0960, 1'b1};
		pulses(2);
		near(16'(last_w), 500, "max on pulse");
		chk(last_g >= 1996 && last_g <= 2006, "first valley");
		trip <= 16'h0014;
		pulses(2);
		chk(last_w >= 20 && last_w <= 24, "current end");
		trip <= 16'h0000;
		pulses(2);
		chk(last_w >= 12 && last_w <= 15, "blanking");
		trip <= 16'hffff;
		sense.fb <= 16'h03e8;
		pulses(2);
		chk(mode === MODE_DISCONT, "mid feedback");
		chk(last_g >= 3996 && last_g <= 4006, "later valley");
		$display("test done: gate");
		sense.fb <= 16'h01f4;
		repeat (10) @(posedge clk_i);
		chk(mode !== MODE_BURST, "burst blanked");
		repeat (30) @(posedge clk_i);
		chk(mode === MODE_BURST && oen === 1'b0 && ien === 1'b0, "burst entry");
		apb(1'b1, `FBM_REG_CTRL, 32'h00000003);
		// The write lands on the ready edge, so look one edge later
		@(posedge clk_i);
		chk(ien === 1'b1, "input guard");
		pulses(3);
		near(16'(last_w), 50, "burst on");
		chk(last_g + last_w >= 1250, "burst spacing");
		k = npulse;
		repeat (10000) @(posedge clk_i);
		chk(npulse - k >= 3 && npulse - k <= 5, "burst count");
		sense.fb <= 16'h03e8;
		repeat (5) @(posedge clk_i);
		chk(mode === MODE_DISCONT && oen === 1'b1, "burst exit");
		apb(1'b1, `FBM_REG_CTRL, 32'h00000000);
		repeat (2) @(posedge clk_i);
		chk(mode === MODE_IDLE && gate === 1'b0, "stop");
		$display("test done: burst");
		complete_run();
	end
endmodule : fbm_top_tb
